// [apm_pkg.sv]
// Shared types and constants for the asymmetric PHY attachment service block.
// Assumes a single 10 MHz system clock and a coding sublayer on the same clock.
package apm_pkg;

  // ==========================================================
  // Clock and timing
  localparam int APM_CLK_NS = 100;
  // Good symbols in a row before a receiver reports OK
  localparam int APM_OK_SYMBOLS = 16;
  localparam int APM_OK_CNT_W = 5;
  // Depth of the transmit symbol buffer
  localparam int APM_FIFO_DEPTH = 32;

  // ==========================================================
  // Transmit mode selection toward the coding sublayer
  typedef enum logic [2:0] {
    sel_data_stream = 3'h0,
    sel_symmetric_training = 3'h1,
    sel_asymmetric_training = 3'h2,
    sel_extended_asym_training = 3'h3,
    sel_send_zeros = 3'h4
  } apm_txmode_t;

  // Fixed role, one bit
  typedef enum logic {
    role_leader = 1'h0,
    role_follower = 1'h1
  } apm_role_t;

  // State reported by PHY control
  typedef enum logic [1:0] {
    ctl_silent = 2'h0,
    ctl_training = 2'h1,
    ctl_data = 2'h2,
    ctl_zeros = 2'h3
  } apm_ctl_t;

  // Link speed variant
  typedef enum logic [1:0] {
    speed_2g5 = 2'h0,
    speed_5g = 2'h1,
    speed_10g = 2'h2
  } apm_speed_t;

  // Symbol levels; zero is the quiet level
  typedef enum logic [2:0] {
    lvl_zero = 3'h0,
    lvl_m1 = 3'h1,
    lvl_m13 = 3'h2,
    lvl_p13 = 3'h3,
    lvl_p1 = 3'h4
  } apm_lvl_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    apm_lvl_t lvl;
  } apm_sym_t;

  typedef struct packed {
    apm_txmode_t mode;
    apm_role_t role;
    logic rate_6g;
    logic pam4;
  } apm_txcfg_t;

  // Reset values
  localparam apm_role_t APM_ROLE_RST = role_leader;
  localparam apm_sym_t APM_SYM_RST = '{valid: 1'b0, lvl: lvl_zero};

endpackage

// [apm_sym_fifo.sv]
// Transmit symbol buffer between the coding sublayer and the line driver.
// Assumes DEPTH is a power of two; both sides on sys_clk.
`timescale 1ns/100ps
module apm_sym_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Empty is exact from the count
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Ready is registered so the top port comes from a flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_q <= wr_q + {{(AW-1){1'b0}}, push};
      rd_q <= rd_q + {{(AW-1){1'b0}}, pop};
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != FULL_CNT);
    end
  end

  // No reset on the array; unread words are never exposed
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // apm_sym_fifo

// [apm_rcvr_monitor.sv]
// Local receiver health: OK after a run of clean symbols, NOT_OK on any error.
// Assumes symbol strobes and error flags arrive on sys_clk.
`timescale 1ns/100ps
module apm_rcvr_monitor
  import apm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sym_valid,
  input wire logic sym_err,
  input wire logic restart,
  output logic rcvr_ok
);
  localparam logic [APM_OK_CNT_W-1:0] OK_LAST = APM_OK_SYMBOLS[APM_OK_CNT_W-1:0] - 5'h1;

  // ==========================================================
  // Clean-run counter
  logic [APM_OK_CNT_W-1:0] run_q;

  // Restart wins so a new phase always starts from NOT_OK
  always_ff @(posedge sys_clk) begin
    if (reset || restart) begin
      run_q <= '0;
      rcvr_ok <= 1'b0;
    end else if (sym_valid && sym_err) begin
      run_q <= '0;
      rcvr_ok <= 1'b0;
    end else if (sym_valid && !rcvr_ok) begin
      if (run_q == OK_LAST) begin
        rcvr_ok <= 1'b1;
      end else begin
        run_q <= run_q + 5'h1;
      end
    end
  end
endmodule // apm_rcvr_monitor

// [apm_pma_service.sv]
// Attachment-side end of the service interface of an asymmetric PHY.
// Assumes PHY control and the coding sublayer run on sys_clk; the line
// receiver and the role strap are asynchronous pins.
`timescale 1ns/100ps
module apm_pma_service
  import apm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire apm_ctl_t ctl_state,
  input wire apm_txmode_t ctl_train_kind,
  input wire apm_speed_t cfg_speed,
  input wire logic cfg_ext_pam4,
  input wire logic cfg_follower_6g,
  input wire logic mgmt_role_we,
  input wire apm_role_t mgmt_role,
  input wire logic role_strap_pin,
  input wire apm_lvl_t tx_symb,
  input wire logic tx_symb_valid,
  output logic tx_symb_ready,
  input wire logic med_ready,
  output apm_sym_t med_sym,
  input wire logic [2:0] rx_line_lvl,
  input wire logic rx_line_tgl,
  output apm_sym_t rx_symb,
  input wire logic pcs_rem_rcvr_ok,
  output logic rem_rcvr_ok,
  output apm_txcfg_t txcfg,
  output logic rx_rate_6g,
  output logic loc_rcvr_ok,
  output logic tx_sym_err,
  output logic tx_tdd_active
);

  // ==========================================================
  // Pin synchronisers
  logic strap_s1_q;
  logic strap_s2_q;
  logic [2:0] rxl_s1_q;
  logic [2:0] rxl_s2_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;

  // Only stages after the first are read by logic; no reset, so the strap and the
  // toggle are already settled when reset lets go and no false edge follows
  always_ff @(posedge sys_clk) begin
    strap_s1_q <= role_strap_pin;
    strap_s2_q <= strap_s1_q;
    rxl_s1_q <= rx_line_lvl;
    rxl_s2_q <= rxl_s1_q;
    tgl_s1_q <= rx_line_tgl;
    tgl_s2_q <= tgl_s1_q;
    tgl_s3_q <= tgl_s2_q;
  end

  // ==========================================================
  // Role: strap after reset, management until operation starts
  apm_role_t role_q;
  logic strap_taken_q;
  logic role_locked_q;
  wire role_open = !role_locked_q && (ctl_state == ctl_silent);

  // Strap caught by clock after release, never by the reset itself
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      role_q <= APM_ROLE_RST;
      strap_taken_q <= 1'b0;
      role_locked_q <= 1'b0;
    end else begin
      strap_taken_q <= 1'b1;
      role_locked_q <= role_locked_q || (ctl_state != ctl_silent);
      if (role_open && mgmt_role_we) begin
        role_q <= mgmt_role;
      end else if (!strap_taken_q) begin
        role_q <= apm_role_t'(strap_s2_q);
      end
    end
  end

  // ==========================================================
  // Mode selection, rate and modulation
  apm_txmode_t mode_d;
  logic rate_d;
  logic pam4_d;
  wire is_lead = (role_q == role_leader);
  wire fast_data = (cfg_speed != speed_2g5);

  // Mode follows PHY control level for level, never pulsed
  always_comb begin
    case (ctl_state)
      ctl_data: mode_d = sel_data_stream;
      ctl_training: mode_d = ctl_train_kind;
      ctl_zeros: mode_d = sel_send_zeros;
      default: mode_d = sel_send_zeros;
    endcase
  end

  // Leader always sends 3G two-level; the follower varies
  always_comb begin
    rate_d = 1'b0;
    pam4_d = 1'b0;
    case (mode_d)
      sel_symmetric_training: rate_d = 1'b0;
      sel_asymmetric_training: rate_d = !is_lead && cfg_follower_6g;
      sel_extended_asym_training: begin
        rate_d = !is_lead;
        pam4_d = !is_lead && cfg_ext_pam4;
      end
      sel_data_stream: begin
        rate_d = !is_lead && fast_data;
        pam4_d = !is_lead && (cfg_speed == speed_10g);
      end
      default: rate_d = 1'b0;
    endcase
  end

  // Registered toward the coding sublayer and transmit function
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      txcfg <= '{mode: sel_send_zeros, role: APM_ROLE_RST, rate_6g: 1'b0, pam4: 1'b0};
      rx_rate_6g <= 1'b0;
    end else begin
      txcfg <= '{mode: mode_d, role: role_q, rate_6g: rate_d, pam4: pam4_d};
      rx_rate_6g <= is_lead && fast_data;
    end
  end

  // ==========================================================
  // TDD activity: set on training entry, dropped when silent
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_tdd_active <= 1'b0;
    end else if (ctl_state == ctl_training) begin
      tx_tdd_active <= 1'b1;
    end else if (ctl_state == ctl_silent) begin
      tx_tdd_active <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit path through the buffer
  logic [2:0] fifo_out;
  logic fifo_valid;
  wire drain = fifo_valid && med_ready;
  wire apm_lvl_t out_lvl = apm_lvl_t'(fifo_out);
  wire is_zero = (out_lvl == lvl_zero);
  wire is_pm1 = (out_lvl == lvl_m1) || (out_lvl == lvl_p1);
  wire is_mid = (out_lvl == lvl_m13) || (out_lvl == lvl_p13);
  // Zero is always legal: quiet and zero requests produce it
  wire lvl_ok = is_zero || is_pm1 || (is_mid && txcfg.pam4);
  wire force_zero = (txcfg.mode == sel_send_zeros) || !lvl_ok;

  // One symbol taken per valid and ready cycle from the coding sublayer
  apm_sym_fifo #(
    .WIDTH(3),
    .DEPTH(APM_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_data(tx_symb),
    .in_valid(tx_symb_valid),
    .in_ready(tx_symb_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(med_ready)
  );

  // Illegal levels are replaced by zero rather than sent
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      med_sym <= APM_SYM_RST;
      tx_sym_err <= 1'b0;
    end else begin
      med_sym.valid <= drain;
      med_sym.lvl <= (drain && !force_zero) ? out_lvl : lvl_zero;
      tx_sym_err <= drain && !lvl_ok;
    end
  end

  // ==========================================================
  // Receive path: each recovered-clock edge gives one symbol
  wire rx_edge = tgl_s2_q ^ tgl_s3_q;
  wire rx_bad = (rxl_s2_q > 3'h4) || (rxl_s2_q == 3'h0);
  apm_txmode_t mode_prev_q;
  wire lead_asym = is_lead && (mode_d != mode_prev_q)
    && ((mode_d == sel_asymmetric_training) || (mode_d == sel_extended_asym_training));
  wire phase_new = (mode_d != mode_prev_q);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_symb <= APM_SYM_RST;
      rem_rcvr_ok <= 1'b0;
      mode_prev_q <= sel_send_zeros;
    end else begin
      rx_symb.valid <= rx_edge;
      rx_symb.lvl <= rx_bad ? lvl_zero : apm_lvl_t'(rxl_s2_q);
      rem_rcvr_ok <= pcs_rem_rcvr_ok;
      mode_prev_q <= mode_d;
    end
  end

  // Status restarts on each phase; leader also on asymmetric entry
  apm_rcvr_monitor u_mon (
    .sys_clk(sys_clk),
    .reset(reset),
    .sym_valid(rx_edge),
    .sym_err(rx_bad),
    .restart(phase_new || lead_asym),
    .rcvr_ok(loc_rcvr_ok)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_DATA_MODE: assert property (
    (ctl_state == ctl_data) [*2] |-> (txcfg.mode == sel_data_stream))
    else $error("data mode not held");
  AST_SYM_RATE: assert property (
    (txcfg.mode == sel_symmetric_training) |-> !txcfg.rate_6g && !txcfg.pam4)
    else $error("symmetric training not 3G two-level");
  AST_ASYM_LEAD: assert property (
    (ctl_state == ctl_training && ctl_train_kind == sel_asymmetric_training
      && role_q == role_leader) |=> !txcfg.rate_6g && !txcfg.pam4)
    else $error("leader not at 3G in asymmetric training");
  AST_EXT_FOLLOW: assert property (
    (txcfg.mode == sel_extended_asym_training) |-> (txcfg.rate_6g == txcfg.role)
      && (!txcfg.pam4 || txcfg.role == role_follower))
    else $error("extended training rate wrong");
  AST_ZEROS: assert property (
    (txcfg.mode == sel_send_zeros) |=> (med_sym.lvl == lvl_zero))
    else $error("nonzero symbol in zeros mode");
  AST_ROLE_HELD: assert property (
    role_locked_q && $past(role_locked_q) |-> $stable(txcfg.role) && $stable(role_q))
    else $error("role changed during operation");
  AST_MEDIUM: assert property (
    drain && !force_zero |=> med_sym.valid && (med_sym.lvl == $past(out_lvl)))
    else $error("symbol not driven to line");
  AST_RX_EACH: assert property (
    (tgl_s1_q != tgl_s2_q) |-> ##2 rx_symb.valid)
    else $error("received symbol lost");
  AST_RX_RATE: assert property (
    $stable(role_q) && role_q == role_follower && $stable(cfg_speed) |=> !rx_rate_6g)
    else $error("follower receive rate not 3G");
  AST_LEAD_CLEAR: assert property (
    lead_asym |=> !loc_rcvr_ok [*2])
    else $error("leader status not cleared");
  AST_TDD: assert property (
    (ctl_state == ctl_training) |=> tx_tdd_active)
    else $error("tdd active not raised");
  // Data paths, follower settings, strap and status
  AST_TX_ILLEGAL: assert property (
    drain && !lvl_ok |=> tx_sym_err && (med_sym.lvl == lvl_zero))
    else $error("illegal level not replaced by zero");
  AST_STRAP_ROLE: assert property (
    !strap_taken_q && !(role_open && mgmt_role_we) |=> (role_q == $past(strap_s2_q)))
    else $error("strap role not taken");
  AST_FOLLOW_ASYM: assert property (
    (ctl_state == ctl_training && ctl_train_kind == sel_asymmetric_training
      && role_q == role_follower) |=> !txcfg.pam4
      && (txcfg.rate_6g == $past(cfg_follower_6g)))
    else $error("follower asymmetric training rate wrong");
  AST_EXT_PAM4: assert property (
    (ctl_state == ctl_training && ctl_train_kind == sel_extended_asym_training
      && role_q == role_follower) |=> txcfg.rate_6g && (txcfg.pam4 == $past(cfg_ext_pam4)))
    else $error("follower extended training setting wrong");
  AST_RX_LEVEL: assert property (
    rx_edge && !rx_bad |=> rx_symb.valid && (rx_symb.lvl == $past(rxl_s2_q)))
    else $error("received level not delivered");
  AST_OK_RUN: assert property (
    $rose(loc_rcvr_ok) |-> $past(rx_edge) && !$past(rx_bad))
    else $error("receiver ok without clean symbol");
  AST_REM_OK: assert property (
    pcs_rem_rcvr_ok |=> rem_rcvr_ok)
    else $error("remote ok not passed on");
  AST_REM_NOT_OK: assert property (
    !pcs_rem_rcvr_ok |=> !rem_rcvr_ok)
    else $error("remote not ok not passed on");

  COV_DATA: cover property ((ctl_state == ctl_training) ##[1:20] (ctl_state == ctl_data));
  COV_FULL: cover property (!tx_symb_ready);
  COV_OK: cover property ($rose(loc_rcvr_ok));
  COV_EXT: cover property (txcfg.mode == sel_extended_asym_training && txcfg.pam4);
  COV_ERR: cover property ($rose(tx_sym_err));
endmodule // apm_pma_service

// [apm_pcs_model.sv]
// Coding sublayer stand-in: pushes symbol bursts, holds remote status.
// Assumes the attachment block samples on the rising edge of sys_clk.
`timescale 1ns/100ps
module apm_pcs_model
  import apm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic push,
  input wire logic [7:0] push_n,
  input wire apm_lvl_t push_lvl,
  input wire logic quiet,
  input wire logic tx_symb_ready,
  output apm_lvl_t tx_symb,
  output logic tx_symb_valid,
  input wire logic info_stb,
  input wire logic info_bit,
  input wire logic info_clr,
  output logic pcs_rem_rcvr_ok
);
  // ==========================================================
  // Transmit burst
  int target;
  int sent;
  logic have_info;
  logic info_q;
  always @(posedge sys_clk) begin
    if (reset) begin
      target <= 0;
      sent <= 0;
    end else begin
      if (push) target <= target + int'(push_n);
      if (tx_symb_valid && tx_symb_ready) sent <= sent + 1;
    end
  end
  // Idle data wobbles so a stale symbol is never mistaken for a fresh one
  always @(negedge sys_clk) begin
    tx_symb_valid <= (target != sent);
    tx_symb <= quiet ? lvl_zero : (target != sent) ? push_lvl : apm_lvl_t'(~tx_symb);
  end
  // ==========================================================
  // Remote receiver status from the latest InfoField
  always @(posedge sys_clk) begin
    if (reset || info_clr) begin
      have_info <= 1'b0;
    end else if (info_stb) begin
      have_info <= 1'b1;
      info_q <= info_bit;
    end
  end
  assign pcs_rem_rcvr_ok = have_info & info_q;
endmodule // apm_pcs_model

// [tb_top.sv]
// Self-checking bench for the attachment service block.
// Assumes inputs change at the falling edge; outputs settle before it.
`timescale 1ns/100ps
module tb_top;
  import apm_pkg::*;
  logic sys_clk, reset, cfg_ext_pam4, cfg_follower_6g, mgmt_role_we, role_strap_pin;
  logic med_ready, rx_line_tgl, tx_symb_valid, tx_symb_ready, pcs_rem_rcvr_ok, rem_rcvr_ok;
  logic rx_rate_6g, loc_rcvr_ok, tx_sym_err, tx_tdd_active, push, quiet, info_stb, info_bit;
  logic info_clr;
  logic [7:0] push_n;
  logic [2:0] rx_line_lvl;
  apm_ctl_t ctl_state;
  apm_txmode_t ctl_train_kind;
  apm_speed_t cfg_speed;
  apm_role_t mgmt_role;
  apm_lvl_t tx_symb, push_lvl, med_last, rx_last;
  apm_sym_t med_sym, rx_symb;
  apm_txcfg_t txcfg;
  int error_cnt, n_compared, acc_cnt, med_cnt, err_tx, rx_cnt, a0, m0;
  apm_txmode_t tk[3] = '{sel_symmetric_training, sel_asymmetric_training,
                         sel_extended_asym_training};
  logic [1:0] fcfg[3] = '{2'h0, 2'h2, 2'h3};

  apm_pma_service apm_pma_service_i (.sys_clk(sys_clk), .reset(reset), .ctl_state(ctl_state),
    .ctl_train_kind(ctl_train_kind), .cfg_speed(cfg_speed), .cfg_ext_pam4(cfg_ext_pam4),
    .cfg_follower_6g(cfg_follower_6g), .mgmt_role_we(mgmt_role_we), .mgmt_role(mgmt_role),
    .role_strap_pin(role_strap_pin), .tx_symb(tx_symb), .tx_symb_valid(tx_symb_valid),
    .tx_symb_ready(tx_symb_ready), .med_ready(med_ready), .med_sym(med_sym),
    .rx_line_lvl(rx_line_lvl), .rx_line_tgl(rx_line_tgl), .rx_symb(rx_symb),
    .pcs_rem_rcvr_ok(pcs_rem_rcvr_ok), .rem_rcvr_ok(rem_rcvr_ok), .txcfg(txcfg),
    .rx_rate_6g(rx_rate_6g), .loc_rcvr_ok(loc_rcvr_ok), .tx_sym_err(tx_sym_err),
    .tx_tdd_active(tx_tdd_active));
  apm_pcs_model apm_pcs_model_i (.sys_clk(sys_clk), .reset(reset), .push(push),
    .push_n(push_n), .push_lvl(push_lvl), .quiet(quiet), .tx_symb_ready(tx_symb_ready),
    .tx_symb(tx_symb), .tx_symb_valid(tx_symb_valid), .info_stb(info_stb),
    .info_bit(info_bit), .info_clr(info_clr), .pcs_rem_rcvr_ok(pcs_rem_rcvr_ok));

  // ==========================================================
  // Clock and port monitors
  initial begin
    sys_clk = 1'b0;
    forever #(APM_CLK_NS / 2) sys_clk = ~sys_clk;
  end
  // Pulses stand one cycle, so they are counted at every rising edge
  always @(posedge sys_clk) begin
    if (tx_symb_valid === 1'b1 && tx_symb_ready === 1'b1) acc_cnt++;
    if (med_sym.valid === 1'b1) begin
      med_cnt++;
      med_last = med_sym.lvl;
    end
    if (tx_sym_err === 1'b1) err_tx++;
    if (rx_symb.valid === 1'b1) begin
      rx_cnt++;
      rx_last = rx_symb.lvl;
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic do_reset(input logic strap);
    role_strap_pin = strap;
    reset = 1'b1;
    cyc(8);
    reset = 1'b0;
    cyc(2);
  endtask
  task automatic set_mode(input apm_ctl_t st, input apm_txmode_t k);
    ctl_state = st;
    ctl_train_kind = k;
    cyc(2);
  endtask
  task automatic role_wr(input apm_role_t r);
    mgmt_role = r;
    mgmt_role_we = 1'b1;
    cyc(1);
    mgmt_role_we = 1'b0;
    cyc(2);
  endtask
  // Burst goes out through the partner; then wait w cycles
  task automatic send(input apm_lvl_t l, input int n, input int w);
    push_lvl = l;
    push_n = 8'(n);
    push = 1'b1;
    cyc(1);
    push = 1'b0;
    cyc(w);
  endtask
  // Toggle spacing of three cycles keeps every edge visible after sync
  task automatic rx_send(input logic [2:0] code, input int n);
    repeat (n) begin
      rx_line_lvl = code;
      rx_line_tgl = ~rx_line_tgl;
      cyc(3);
    end
    cyc(2);
  endtask
  task automatic end_sim;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {cfg_ext_pam4, cfg_follower_6g, mgmt_role_we, med_ready, rx_line_tgl} = 5'h0;
    {push, quiet, info_stb, info_bit, info_clr, push_n, rx_line_lvl} = 16'h0;
    ctl_state = ctl_silent;
    ctl_train_kind = sel_data_stream;
    cfg_speed = speed_10g;
    mgmt_role = role_leader;
    push_lvl = lvl_p1;
    {error_cnt, n_compared} = 64'h0;
    {acc_cnt, med_cnt, err_tx, rx_cnt} = 128'h0;
    do_reset(1'b0);
    chk(8'(txcfg), 8'({sel_send_zeros, role_leader, 2'h0}));
    chk({tx_symb_ready, med_sym, rx_symb[3], loc_rcvr_ok, tx_sym_err}, 8'h80);
    role_wr(role_follower);
    chk(8'(txcfg.role), 8'(role_follower));
    role_wr(role_leader);
    // Leader stays slow and two-level in every training kind
    {cfg_follower_6g, cfg_ext_pam4} = 2'h3;
    for (int i = 0; i < 3; i++) begin
      set_mode(ctl_training, tk[i]);
      chk(8'(txcfg), 8'({tk[i], role_leader, 2'h0}));
    end
    chk({tx_tdd_active, rx_rate_6g}, 8'h3);
    role_wr(role_follower);
    chk(8'(txcfg.role), 8'(role_leader));
    set_mode(ctl_data, sel_data_stream);
    chk(8'(txcfg), 8'({sel_data_stream, role_leader, 2'h0}));
    med_ready = 1'b1;
    send(lvl_p1, 1, 8);
    chk({med_cnt[3:0], 1'b0, med_last}, 8'h14);
    send(lvl_m13, 1, 8);
    chk({med_cnt[3:0], 1'b0, med_last}, 8'h20);
    chk(8'(err_tx), 8'h1);
    // Receive health: sixteen clean symbols, then one bad code
    rx_send(3'h4, 16);
    chk({loc_rcvr_ok, 7'(rx_cnt)}, 8'h90);
    chk(8'(rx_last), 8'(lvl_p1));
    rx_send(3'h7, 1);
    chk({loc_rcvr_ok, 4'h0, rx_last}, 8'h00);
    rx_send(3'h1, 16);
    chk(8'(loc_rcvr_ok), 8'h1);
    set_mode(ctl_training, sel_asymmetric_training);
    chk(8'(loc_rcvr_ok), 8'h0);
    // Zeros mode flattens even a nonzero symbol
    set_mode(ctl_zeros, sel_data_stream);
    chk(8'(txcfg.mode), 8'(sel_send_zeros));
    send(lvl_p1, 1, 8);
    chk(8'(med_last), 8'(lvl_zero));
    {info_bit, info_stb} = 2'h3;
    cyc(1);
    info_stb = 1'b0;
    cyc(3);
    chk(8'(rem_rcvr_ok), 8'h1);
    info_clr = 1'b1;
    cyc(1);
    info_clr = 1'b0;
    cyc(3);
    chk(8'(rem_rcvr_ok), 8'h0);
    // Fill the buffer against a stalled line, then drain it
    set_mode(ctl_data, sel_data_stream);
    // Quiet partner in data mode: the zeros must pass through untouched
    quiet = 1'b1;
    send(lvl_p1, 1, 8);
    chk({med_cnt[3:0], 1'b0, med_last}, 8'h40);
    quiet = 1'b0;
    {med_ready, a0, m0} = {1'b0, acc_cnt, med_cnt};
    send(lvl_p1, 40, 45);
    chk(8'(acc_cnt - a0), 8'h20);
    chk(8'(tx_symb_ready), 8'h0);
    med_ready = 1'b1;
    cyc(70);
    chk(8'(med_cnt - m0), 8'h28);
    // Follower from the strap, fast in asymmetric and extended training
    ctl_state = ctl_silent;
    do_reset(1'b1);
    chk({7'h0, txcfg.role}, 8'(role_follower));
    for (int i = 0; i < 3; i++) begin
      set_mode(ctl_training, tk[i]);
      chk(8'(txcfg), 8'({tk[i], role_follower, fcfg[i]}));
    end
    chk(8'(rx_rate_6g), 8'h0);
    cfg_follower_6g = 1'b0;
    set_mode(ctl_training, sel_asymmetric_training);
    chk(8'(txcfg.rate_6g), 8'h0);
    set_mode(ctl_data, sel_data_stream);
    chk(8'(txcfg), 8'({sel_data_stream, role_follower, 2'h3}));
    a0 = err_tx;
    send(lvl_p13, 1, 8);
    chk({3'(err_tx - a0), 1'b0, med_last}, 8'(lvl_p13));
    end_sim();
  end
endmodule // tb_top
